// ==== rtl/bspr_pkg.sv ====
// Package: constants for the boot strap and pad reset mux
package bspr_pkg;

	// ----------------------------------------
	// Boot modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		BSPR_BOOT_DEFAULT  = 2'h0,
		BSPR_BOOT_FLASH    = 2'h1,
		BSPR_BOOT_DOWNLOAD = 2'h2
	} bspr_boot_e;

	// ----------------------------------------
	// Pad reset configuration codes
	// ----------------------------------------
	localparam logic [1:0] BSPR_CFG_OFF  = 2'h0;
	localparam logic [1:0] BSPR_CFG_IN   = 2'h1;
	localparam logic [1:0] BSPR_CFG_PD   = 2'h2;
	localparam logic [1:0] BSPR_CFG_PU   = 2'h3;

	// ----------------------------------------
	// Function selection
	// ----------------------------------------
	localparam int         BSPR_FUNC_COUNT = 6;
	localparam logic [2:0] BSPR_FUNC_GPIO  = 3'h2;
	localparam logic [2:0] BSPR_FUNC_RESET = 3'h0;

	// Strap values after reset (default state A=1, B=0)
	localparam logic       BSPR_STRAP_A_RST = 1'b1;
	localparam logic       BSPR_STRAP_B_RST = 1'b0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int BSPR_CLK_HZ       = 40_000_000;
	localparam int BSPR_HOLD_MS      = 3;
	localparam int BSPR_HOLD_CYCLES  = (BSPR_CLK_HZ / 1000) * BSPR_HOLD_MS;
	localparam int BSPR_SYNC_STAGES  = 3;

endpackage

// ==== rtl/bspr_pad_cell.sv ====
// Per-pad configuration and function selection cell
`timescale 1ns/100ps
`default_nettype none

module bspr_pad_cell (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       cfg_wr,
	input  wire logic [1:0] cfg_reset_code,
	input  wire logic [1:0] cfg_code,
	input  wire logic [2:0] cfg_func,
	input  wire logic       cfg_route_en,
	input  wire logic [5:0] func_out,
	input  wire logic [5:0] func_oe,
	input  wire logic       route_out,
	input  wire logic       route_oe,
	output logic            pad_out,
	output logic            pad_oe,
	output logic            input_buffer_enable,
	output logic            weak_pulldown_enable,
	output logic            weak_pullup_enable,
	output logic [2:0]      func_sel,
	output logic            route_sel
);

	logic [1:0] code_r;
	logic [1:0] code_nxt;
	logic [2:0] func_r;
	logic [2:0] func_nxt;
	logic       route_r;
	logic       route_nxt;
	logic       loaded_r;
	logic       loaded_nxt;
	logic       out_nxt;
	logic       oe_nxt;
	logic       ie_r;
	logic       pd_r;
	logic       pu_r;
	logic       out_r;
	logic       oe_r;

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	always_comb begin
		code_nxt   = code_r;
		func_nxt   = func_r;
		route_nxt  = route_r;
		loaded_nxt = 1'b1;
		if (!loaded_r) begin
			code_nxt  = cfg_reset_code;
			func_nxt  = bspr_pkg::BSPR_FUNC_RESET;
			route_nxt = 1'b0;
		end else if (cfg_wr) begin
			code_nxt  = cfg_code;
			route_nxt = cfg_route_en;
			if (cfg_func < 3'(bspr_pkg::BSPR_FUNC_COUNT)) begin
				func_nxt = cfg_func;
			end
		end
		if (route_r) begin
			out_nxt = route_out;
			oe_nxt  = route_oe;
		end else begin
			out_nxt = func_out[func_r];
			oe_nxt  = func_oe[func_r];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			code_r   <= bspr_pkg::BSPR_CFG_OFF;
			func_r   <= bspr_pkg::BSPR_FUNC_RESET;
			route_r  <= 1'b0;
			loaded_r <= 1'b0;
			ie_r     <= 1'b0;
			pd_r     <= 1'b0;
			pu_r     <= 1'b0;
			out_r    <= 1'b0;
			oe_r     <= 1'b0;
		end else begin
			code_r   <= code_nxt;
			func_r   <= func_nxt;
			route_r  <= route_nxt;
			loaded_r <= loaded_nxt;
			ie_r     <= (code_nxt != bspr_pkg::BSPR_CFG_OFF);
			pd_r     <= (code_nxt == bspr_pkg::BSPR_CFG_PD);
			pu_r     <= (code_nxt == bspr_pkg::BSPR_CFG_PU);
			out_r    <= out_nxt;
			oe_r     <= oe_nxt;
		end
	end

	assign input_buffer_enable  = ie_r;
	assign weak_pulldown_enable = pd_r;
	assign weak_pullup_enable   = pu_r;
	assign func_sel             = func_r;
	assign route_sel            = route_r;
	assign pad_out              = out_r;
	assign pad_oe               = oe_r;

endmodule // bspr_pad_cell
`default_nettype wire

// ==== rtl/bspr_top.sv ====
// Top: boot strap capture, boot mode decode and pad reset mux
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Strap levels are caught when reset ends and held for the whole boot.
// - Strap A high means flash boot, both low means download boot, default is A=1 B=0.
// - Download boot accepts firmware over the UART path or the SDIO path.
// - Pad code 0 input off, 1 input on, 2 input with pull-down, 3 input with pull-up.
// - After reset each pad uses its direct-mux default function until software changes it.
// - A routing matrix can connect any peripheral signal to any pad.
module bspr_top #(
	parameter int NUM_PADS    = 8,
	parameter int NUM_SIGS    = 8,
	parameter int HOLD_CYCLES = bspr_pkg::BSPR_HOLD_CYCLES
) (
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic                        chip_power_up_enable,
	input  wire logic                        boot_strap_a,
	input  wire logic                        boot_strap_b,
	input  wire logic                        uart_dl_valid,
	input  wire logic                        sdio_dl_valid,
	input  wire logic [2*NUM_PADS-1:0]       pad_reset_code,
	input  wire logic [$clog2(NUM_PADS)-1:0] cfg_pad,
	input  wire logic                        cfg_wr,
	input  wire logic [1:0]                  cfg_code,
	input  wire logic [2:0]                  cfg_func,
	input  wire logic                        cfg_route_en,
	input  wire logic [$clog2(NUM_SIGS)-1:0] cfg_route_sig,
	input  wire logic [6*NUM_PADS-1:0]       func_out,
	input  wire logic [6*NUM_PADS-1:0]       func_oe,
	input  wire logic [NUM_PADS-1:0]         gpio_out,
	input  wire logic [NUM_PADS-1:0]         gpio_oe,
	input  wire logic [NUM_SIGS-1:0]         periph_out,
	input  wire logic [NUM_SIGS-1:0]         periph_oe,
	output logic [1:0]                       boot_mode,
	output logic                             strap_valid,
	output logic                             pins_released,
	output logic                             dl_accept_uart,
	output logic                             dl_accept_sdio,
	output logic [NUM_PADS-1:0]              pad_out,
	output logic [NUM_PADS-1:0]              pad_oe,
	output logic [NUM_PADS-1:0]              input_buffer_enable,
	output logic [NUM_PADS-1:0]              weak_pulldown_enable,
	output logic [NUM_PADS-1:0]              weak_pullup_enable
);

	localparam int PW = $clog2(NUM_PADS);
	localparam int SW = $clog2(NUM_SIGS);
	localparam int CW = $clog2(HOLD_CYCLES + 1);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] sa_sync_r;
	logic [2:0] sb_sync_r;
	logic [2:0] pu_sync_r;
	logic       sa_ok;
	logic       sb_ok;
	logic       pu_ok;

	// Straps shift through reset so real pin levels stand at release
	always_ff @(posedge clock) begin
		sa_sync_r <= {sa_sync_r[1:0], boot_strap_a};
		sb_sync_r <= {sb_sync_r[1:0], boot_strap_b};
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pu_sync_r <= 3'h0;
		end else begin
			pu_sync_r <= {pu_sync_r[1:0], chip_power_up_enable};
		end
	end

	// Stage 2 and 3 must agree (power-up enable: both high)
	assign sa_ok = (sa_sync_r[1] == sa_sync_r[2]);
	assign sb_ok = (sb_sync_r[1] == sb_sync_r[2]);
	assign pu_ok = pu_sync_r[1] & pu_sync_r[2];

	// ----------------------------------------
	// Strap capture and boot decode
	// ----------------------------------------
	typedef enum logic [1:0] {
		BSPR_ST_WAIT  = 2'b00,
		BSPR_ST_HOLD  = 2'b01,
		BSPR_ST_RUN   = 2'b10
	} bspr_state_e;

	bspr_state_e        st_r;
	bspr_state_e        st_nxt;
	logic [CW-1:0]      cnt_r;
	logic [CW-1:0]      cnt_nxt;
	logic [1:0]         mode_r;
	logic [1:0]         mode_nxt;
	logic               valid_r;
	logic               valid_nxt;
	logic               rel_r;
	logic               rel_nxt;
	logic               dlu_r;
	logic               dlu_nxt;
	logic               dls_r;
	logic               dls_nxt;

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		mode_nxt  = mode_r;
		valid_nxt = valid_r;
		rel_nxt   = rel_r;
		unique case (st_r)
			BSPR_ST_WAIT: begin
				if (sa_ok && sb_ok) begin
					valid_nxt = 1'b1;
					st_nxt    = BSPR_ST_HOLD;
					if (sa_sync_r[2]) begin
						mode_nxt = bspr_pkg::BSPR_BOOT_FLASH;
					end else if (!sb_sync_r[2]) begin
						mode_nxt = bspr_pkg::BSPR_BOOT_DOWNLOAD;
					end else begin
						mode_nxt = bspr_pkg::BSPR_BOOT_DEFAULT;
					end
				end
			end
			BSPR_ST_HOLD: begin
				if (pu_ok) begin
					if (cnt_r >= CW'(HOLD_CYCLES - 1)) begin
						rel_nxt = 1'b1;
						st_nxt  = BSPR_ST_RUN;
					end else begin
						cnt_nxt = cnt_r + CW'(1);
					end
				end else begin
					cnt_nxt = '0;
				end
			end
			BSPR_ST_RUN: begin
				st_nxt = BSPR_ST_RUN;
			end
			default: begin
				st_nxt = BSPR_ST_WAIT;
			end
		endcase
		dlu_nxt = (mode_r == bspr_pkg::BSPR_BOOT_DOWNLOAD) && rel_r && uart_dl_valid;
		dls_nxt = (mode_r == bspr_pkg::BSPR_BOOT_DOWNLOAD) && rel_r && sdio_dl_valid;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_r    <= BSPR_ST_WAIT;
			cnt_r   <= '0;
			mode_r  <= bspr_pkg::BSPR_BOOT_DEFAULT;
			valid_r <= 1'b0;
			rel_r   <= 1'b0;
			dlu_r   <= 1'b0;
			dls_r   <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			mode_r  <= mode_nxt;
			valid_r <= valid_nxt;
			rel_r   <= rel_nxt;
			dlu_r   <= dlu_nxt;
			dls_r   <= dls_nxt;
		end
	end

	assign boot_mode      = mode_r;
	assign strap_valid    = valid_r;
	assign pins_released  = rel_r;
	assign dl_accept_uart = dlu_r;
	assign dl_accept_sdio = dls_r;

	// ----------------------------------------
	// Routing matrix selection per pad
	// ----------------------------------------
	logic [SW-1:0] rsig_r [NUM_PADS];

	// ----------------------------------------
	// Pad cells
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PADS; gi++) begin : g_pad
			logic       wr;
			logic [5:0] fo;
			logic [5:0] fe;
			logic       ro;
			logic       re;

			assign wr = cfg_wr && (cfg_pad == PW'(gi));

			always_ff @(posedge clock) begin
				if (rst) begin
					rsig_r[gi] <= '0;
				end else if (wr) begin
					rsig_r[gi] <= cfg_route_sig;
				end
			end

			always_comb begin
				fo = func_out[6*gi +: 6];
				fe = func_oe[6*gi +: 6];
				fo[bspr_pkg::BSPR_FUNC_GPIO] = gpio_out[gi];
				fe[bspr_pkg::BSPR_FUNC_GPIO] = gpio_oe[gi];
				// Strap pins stay inputs until released
				if (!rel_r) begin
					fe = 6'h00;
				end
			end

			assign ro = periph_out[rsig_r[gi]];
			assign re = periph_oe[rsig_r[gi]] & rel_r;

			bspr_pad_cell u_cell (
				.clock                (clock),
				.rst                  (rst),
				.cfg_wr               (wr),
				.cfg_reset_code       (pad_reset_code[2*gi +: 2]),
				.cfg_code             (cfg_code),
				.cfg_func             (cfg_func),
				.cfg_route_en         (cfg_route_en),
				.func_out             (fo),
				.func_oe              (fe),
				.route_out            (ro),
				.route_oe             (re),
				.pad_out              (pad_out[gi]),
				.pad_oe               (pad_oe[gi]),
				.input_buffer_enable  (input_buffer_enable[gi]),
				.weak_pulldown_enable (weak_pulldown_enable[gi]),
				.weak_pullup_enable   (weak_pullup_enable[gi]),
				.func_sel             (),
				.route_sel            ()
			);
		end
	endgenerate

endmodule // bspr_top
`default_nettype wire

// ==== testbench/bspr_checker.sv ====
// Checker for the boot strap and pad reset mux
`timescale 1ns/100ps
`default_nettype none
module bspr_checker #(
	parameter int NUM_PADS    = 8,
	parameter int HOLD_CYCLES = 20
) (
	input wire logic                        clock,
	input wire logic                        rst,
	input wire logic                        uart_dl_valid,
	input wire logic [$clog2(NUM_PADS)-1:0] cfg_pad,
	input wire logic                        cfg_wr,
	input wire logic [1:0]                  cfg_code,
	input wire logic [1:0]                  boot_mode,
	input wire logic                        strap_valid,
	input wire logic                        pins_released,
	input wire logic                        dl_accept_uart,
	input wire logic                        dl_accept_sdio,
	input wire logic [NUM_PADS-1:0]         pad_oe,
	input wire logic [NUM_PADS-1:0]         input_buffer_enable,
	input wire logic [NUM_PADS-1:0]         weak_pulldown_enable,
	input wire logic [NUM_PADS-1:0]         weak_pullup_enable
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_valid_keeps: assert property (strap_valid |=> strap_valid)
		else $error("strap valid dropped");
	a_mode_frozen: assert property (strap_valid && $past(strap_valid) |-> $stable(boot_mode))
		else $error("boot mode changed after capture");
	a_release_late: assert property ($rose(pins_released) |-> $past(strap_valid, HOLD_CYCLES - 1))
		else $error("pins released too early");
	a_oe_held_off: assert property (!pins_released |-> pad_oe == '0)
		else $error("pad driven during hold");
	a_dl_gated: assert property (dl_accept_uart || dl_accept_sdio |->
		boot_mode == bspr_pkg::BSPR_BOOT_DOWNLOAD && pins_released)
		else $error("download accepted outside download mode");
	a_uart_follows: assert property (pins_released &&
		boot_mode == bspr_pkg::BSPR_BOOT_DOWNLOAD |=> dl_accept_uart == $past(uart_dl_valid))
		else $error("uart accept wrong");
	a_pull_legal: assert property (((weak_pulldown_enable | weak_pullup_enable)
		& ~input_buffer_enable) == '0 && (weak_pulldown_enable & weak_pullup_enable) == '0)
		else $error("illegal pull combination");
	a_code_write: assert property (cfg_wr |=> input_buffer_enable[$past(cfg_pad)]
		== ($past(cfg_code) != 2'h0))
		else $error("input enable not written");
	cover property ($rose(pins_released));
	cover property (dl_accept_sdio);
	cover property (cfg_wr && cfg_code == 2'h3);
endmodule // bspr_checker

bind bspr_top bspr_checker #(.NUM_PADS(NUM_PADS), .HOLD_CYCLES(HOLD_CYCLES)) u_bspr_checker (
	.clock(clock), .rst(rst), .uart_dl_valid(uart_dl_valid), .cfg_pad(cfg_pad),
	.cfg_wr(cfg_wr), .cfg_code(cfg_code), .boot_mode(boot_mode), .strap_valid(strap_valid),
	.pins_released(pins_released), .dl_accept_uart(dl_accept_uart),
	.dl_accept_sdio(dl_accept_sdio), .pad_oe(pad_oe),
	.input_buffer_enable(input_buffer_enable), .weak_pulldown_enable(weak_pulldown_enable),
	.weak_pullup_enable(weak_pullup_enable));
`default_nettype wire

// ==== testbench/bspr_board.sv ====
// Board model: strap resistors and power-up enable
`timescale 1ns/100ps
`default_nettype none
module bspr_board #(
	parameter int HOLD = 20
) (
	input  wire logic clock,
	input  wire logic pwr,
	input  wire logic want_a,
	input  wire logic want_b,
	output logic      boot_strap_a,
	output logic      boot_strap_b,
	output logic      chip_power_up_enable
);
	int   cnt = 0;
	logic tgl = 1'b0;
	assign chip_power_up_enable = pwr;
	always @(posedge clock) begin
		cnt <= pwr ? (cnt < HOLD + 8 ? cnt + 1 : cnt) : 0;
		tgl <= ~tgl;
	end
	assign boot_strap_a = (cnt < HOLD + 8) ? want_a : tgl;
	assign boot_strap_b = (cnt < HOLD + 8) ? want_b : ~tgl;
endmodule // bspr_board
`default_nettype wire

// ==== testbench/boot_strap_and_pad_reset_mux_bench.sv ====
// Testbench for the boot strap and pad reset mux
`timescale 1ns/100ps
`default_nettype none
module boot_strap_and_pad_reset_mux_bench;
	localparam int HC = 20;
	logic        clock = 0, rst = 1, pwr = 0, sa = 1, sb = 0, uv = 0, sv = 0, cw = 0, cre = 0;
	logic [15:0] prc = '0;
	logic [2:0]  cp = '0, cf = '0, crs = '0;
	logic [1:0]  cc = '0;
	logic [47:0] fo = '0, foe = '0;
	logic [7:0]  go = '0, goe = '0, po = '0, poe = '0;
	logic        bsa, bsb, cpe, svd, rel, dau, das;
	logic [1:0]  bm;
	logic [7:0]  pout, poe_o, ie, pd, pu;
	logic [2:0]  fn [8], rs [8];
	logic        rt [8];
	int          bad_count = 0, n_checks = 0, cyc = 0;

	always #12.5 clock = ~clock;

	bspr_board #(.HOLD(HC)) u_bspr_board (.clock(clock), .pwr(pwr), .want_a(sa), .want_b(sb),
		.boot_strap_a(bsa), .boot_strap_b(bsb), .chip_power_up_enable(cpe));

	bspr_top #(.HOLD_CYCLES(HC)) u_bspr_top (.clock(clock), .rst(rst),
		.chip_power_up_enable(cpe), .boot_strap_a(bsa), .boot_strap_b(bsb),
		.uart_dl_valid(uv), .sdio_dl_valid(sv), .pad_reset_code(prc), .cfg_pad(cp),
		.cfg_wr(cw), .cfg_code(cc), .cfg_func(cf), .cfg_route_en(cre), .cfg_route_sig(crs),
		.func_out(fo), .func_oe(foe), .gpio_out(go), .gpio_oe(goe), .periph_out(po),
		.periph_oe(poe), .boot_mode(bm), .strap_valid(svd), .pins_released(rel),
		.dl_accept_uart(dau), .dl_accept_sdio(das), .pad_out(pout), .pad_oe(poe_o),
		.input_buffer_enable(ie), .weak_pulldown_enable(pd), .weak_pullup_enable(pu));

	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	task print_verdict;
		if (bad_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	function automatic logic [1:0] mode_of(input logic a, input logic b);
		return a ? 2'h1 : (!b) ? 2'h2 : 2'h0;
	endfunction

	// Expected input, pull-down, pull-up
	function automatic logic [2:0] pulls(input logic [1:0] c);
		return {c != 2'h0, c == 2'h2, c == 2'h3};
	endfunction

	function automatic logic [1:0] drive(input int i);
		if (rt[i]) return {po[rs[i]], poe[rs[i]]};
		if (fn[i] == 3'h2) return {go[i], goe[i]};
		return {fo[6*i+fn[i]], foe[6*i+fn[i]]};
	endfunction

	always @(posedge clock) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			print_verdict();
		end
	end

	initial begin
		int k;
		void'($urandom(32'h733e));
		for (int m = 0; m < 4; m++) begin
			@(negedge clock);
			rst = 1;
			pwr = 0;
			{sa, sb} = 2'(m);
			prc = 16'($urandom);
			{fo, foe} = {$urandom, $urandom, $urandom};
			{go, goe, po, poe} = $urandom;
			repeat (4) @(negedge clock);
			rst = 0;
			pwr = 1;
			for (int i = 0; i < 8; i++) begin
				fn[i] = 3'h0;
				rt[i] = 1'b0;
				rs[i] = 3'h0;
			end
			repeat (3) @(negedge clock);
			chk("valid", 8'(svd), 8'h1);
			chk("mode", 8'(bm), 8'(mode_of(sa, sb)));
			for (int i = 0; i < 8; i++) chk("rst_pull", 8'({ie[i], pd[i], pu[i]}), 8'(pulls(prc[2*i+:2])));
			k = 0;
			while (!rel && k < 60) begin
				@(negedge clock);
				k++;
			end
			chk("hold", 8'(k + 3 >= HC && k + 3 <= HC + 8), 8'h1);
			@(negedge clock);
			for (int i = 0; i < 8; i++) chk("dflt", 8'({pout[i], poe_o[i]}), 8'(drive(i)));
			repeat (12) @(negedge clock);
			chk("mode_kept", 8'(bm), 8'(mode_of(sa, sb)));
			for (int j = 0; j < 4; j++) begin
				{uv, sv} = 2'(j);
				@(negedge clock);
				chk("dl", 8'({dau, das}), (m == 0) ? 8'(j) : 8'h0);
			end
			for (int w = 0; w < 12; w++) begin
				cp = 3'($urandom);
				cc = 2'($urandom);
				cf = w[0] ? 3'h2 : 3'($urandom);
				cre = w[1] & w[2];
				crs = 3'($urandom);
				cw = 1;
				@(negedge clock);
				cw = 0;
				if (cf < 3'h6) fn[cp] = cf;
				rt[cp] = cre;
				rs[cp] = crs;
				chk("pull", 8'({ie[cp], pd[cp], pu[cp]}), 8'(pulls(cc)));
				@(negedge clock);
				chk("pad", 8'({pout[cp], poe_o[cp]}), 8'(drive(cp)));
			end
		end
		print_verdict();
	end
endmodule // boot_strap_and_pad_reset_mux_bench
`default_nettype wire
